// ---- core/rtbm_manager.v ----
`timescale 1ns/1ps
`include "rtbm_defs.vh"
module rtbm_manager (
  input  wire        mclk,
  input  wire        resetn,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [15:0] reg_rdata,
  // protocol engine side
  input  wire        msg_start,
  input  wire [15:0] cmd_word,
  input  wire        cmd_bcst,
  input  wire        bcst_sep,
  input  wire        legacy_compat_mode,
  input  wire        no_upd_invalid,
  input  wire        word_req,
  input  wire [15:0] word_wdata,
  output reg  [15:0] word_rdata,
  output reg         word_ack,
  input  wire        msg_end,
  input  wire        msg_valid,
  input  wire [15:0] desc_addr,
  output reg         busy,
  output reg         irq_msg,
  output reg         irq_rollover,
  output reg         irq_mode,
  // shared ram side
  output reg  [15:0] ram_addr,
  output reg  [15:0] ram_wdata,
  output reg         ram_wr,
  output reg         ram_rd,
  input  wire [15:0] ram_rdata,
  input  wire        ram_ack
);
  localparam S_IDLE   = 4'h0;
  localparam S_RDPTR  = 4'h1;
  localparam S_RDSACW = 4'h2;
  localparam S_DESC3  = 4'h3;
  localparam S_DESC4  = 4'h4;
  localparam S_DATA   = 4'h5;
  localparam S_WORD   = 4'h6;
  localparam S_UPD    = 4'h7;
  localparam S_MCI    = 4'h8;

  wire [15:0] cfg1;
  reg  [3:0]  state;
  reg  [15:0] ptr;
  reg  [15:0] sacw;
  reg  [15:0] cmd;
  reg         bcst;
  reg  [5:0]  count;
  reg  [15:0] lut_addr;
  reg         rolled;
  wire        tx      = cmd[10];
  wire [4:0]  sa      = cmd[9:5];
  wire        mode_sa = (sa == 5'h00) || (sa == 5'h1F);
  wire [15:0] lut_base = cfg1[`RTBM_AREA_BIT] ? `RTBM_LUT_B : `RTBM_LUT_A;
  wire [15:0] next_ptr;
  wire        wrapped;
  reg  [4:0]  sacw_fld;
  reg  [2:0]  size_code;
  reg         dbl_en;

  rtbm_regs u_regs (
    .mclk      (mclk),
    .resetn    (resetn),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .stat_in   ({12'h000, state}),
    .ptr_in    (ptr),
    .irq_in    ({13'h0000, irq_mode, irq_rollover, irq_msg}),
    .cfg1      (cfg1)
  );

  always @* begin
    sacw_fld = tx ? sacw[14:10] : (bcst ? sacw[4:0] : sacw[9:5]);
    size_code = sacw_fld[2:0];
    dbl_en = sacw[`RTBM_SACW_DBL] && !tx;
    if (legacy_compat_mode) begin
      size_code = 3'h0;
      dbl_en = 1'b0;
    end
  end

  rtbm_ptr_calc u_calc (
    .ptr       (ptr),
    .size_code (size_code),
    .count     (count),
    .next_ptr  (next_ptr),
    .wrapped   (wrapped)
  );

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      ptr <= 16'h0000;
      sacw <= 16'h0000;
      cmd <= 16'h0000;
      bcst <= 1'b0;
      count <= 6'h00;
      lut_addr <= 16'h0000;
      rolled <= 1'b0;
      busy <= 1'b0;
      word_ack <= 1'b0;
      word_rdata <= 16'h0000;
      irq_msg <= 1'b0;
      irq_rollover <= 1'b0;
      irq_mode <= 1'b0;
      ram_addr <= 16'h0000;
      ram_wdata <= 16'h0000;
      ram_wr <= 1'b0;
      ram_rd <= 1'b0;
    end else begin
      word_ack <= 1'b0;
      irq_msg <= 1'b0;
      irq_rollover <= 1'b0;
      irq_mode <= 1'b0;
      case (state)
        S_IDLE: begin
          if (msg_start) begin
            cmd <= cmd_word;
            bcst <= cmd_bcst && bcst_sep;
            count <= 6'h00;
            rolled <= 1'b0;
            busy <= 1'b1;
            lut_addr <= lut_base + (cmd_word[10] ? `RTBM_LUT_TX :
                        ((cmd_bcst && bcst_sep) ? `RTBM_LUT_BC : 16'h0000)) +
                        {11'h000, cmd_word[9:5]};
            ram_addr <= lut_base + (cmd_word[10] ? `RTBM_LUT_TX :
                        ((cmd_bcst && bcst_sep) ? `RTBM_LUT_BC : 16'h0000)) +
                        {11'h000, cmd_word[9:5]};
            ram_rd <= 1'b1;
            state <= S_RDPTR;
          end
        end
        S_RDPTR: begin
          if (ram_ack) begin
            ptr <= ram_rdata;
            ram_addr <= lut_base + `RTBM_LUT_SACW + {11'h000, sa};
            state <= S_RDSACW;
          end
        end
        S_RDSACW: begin
          if (ram_ack) begin
            sacw <= ram_rdata;
            ram_rd <= 1'b0;
            ram_addr <= desc_addr + 16'h0002;
            ram_wdata <= ptr;
            ram_wr <= 1'b1;
            state <= S_DESC3;
          end
        end
        S_DESC3: begin
          if (ram_ack) begin
            ram_addr <= desc_addr + 16'h0003;
            ram_wdata <= cmd;
            state <= S_DESC4;
          end
        end
        S_DESC4: begin
          if (ram_ack) begin
            ram_wr <= 1'b0;
            state <= S_DATA;
          end
        end
        S_DATA: begin
          if (msg_end) begin
            state <= S_UPD;
          end else if (word_req && !word_ack && count < `RTBM_MAX_BLOCK) begin
            if (size_code != 3'h0)
              ram_addr <= next_ptr;
            else
              ram_addr <= ptr + {10'h000, count};
            if (size_code != 3'h0 && wrapped)
              rolled <= 1'b1;
            ram_wdata <= word_wdata;
            ram_wr <= !tx;
            ram_rd <= tx;
            state <= S_WORD;
          end
        end
        S_WORD: begin
          if (ram_ack) begin
            word_rdata <= ram_rdata;
            word_ack <= 1'b1;
            ram_wr <= 1'b0;
            ram_rd <= 1'b0;
            count <= count + 6'h01;
            state <= S_DATA;
          end
        end
        S_UPD: begin
          ram_addr <= lut_addr;
          ram_wr <= 1'b0;
          state <= S_MCI;
          if (size_code != 3'h0) begin
            if (msg_valid || !(no_upd_invalid && !tx)) begin
              ram_wdata <= next_ptr;
              ram_wr <= 1'b1;
              ptr <= next_ptr;
            end
          end else if (dbl_en && msg_valid) begin
            ram_wdata <= ptr ^ (16'h0001 << `RTBM_DBL_BIT);
            ram_wr <= 1'b1;
            ptr <= ptr ^ (16'h0001 << `RTBM_DBL_BIT);
          end // single message: pointer kept
          irq_msg <= sacw_fld[`RTBM_SACW_MSG_IRQ] && !legacy_compat_mode;
          irq_rollover <= sacw_fld[`RTBM_SACW_CIRC_IRQ] && (rolled ||
                          (size_code != 3'h0 && wrapped));
        end
        S_MCI: begin
          if (ram_wr && !ram_ack) begin
            state <= S_MCI;
          end else if (mode_sa && !ram_rd) begin
            ram_wr <= 1'b0;
            ram_rd <= 1'b1;
            ram_addr <= `RTBM_MCI_TABLE + {13'h0000, bcst, tx, cmd[4]};
          end else if (mode_sa && ram_ack) begin
            ram_rd <= 1'b0;
            irq_mode <= ram_rdata[cmd[3:0]];
            busy <= 1'b0;
            state <= S_IDLE;
          end else if (!mode_sa) begin
            ram_wr <= 1'b0;
            busy <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- core/rtbm_defs.vh ----
// Contract
// - three-bit size code: 000 single/double, 001..111 circular 128..8192 words
// - per-subaddress interrupts: every message (not in legacy compatible mode), and circular buffer rollover, control-word enabled
// - mode code interrupt decided from a separate table in RAM
// - legacy compatible mode forces single-message buffering everywhere
// - area select bit 13 of config register 1 picks the lookup table set
// - received command word written to descriptor word four
// - lookup index from T/R, subaddress, optional broadcast; pointer read from active table
// - a single message data block never exceeds 32 words
// - single-message mode leaves lookup pointer unchanged
// - lookup entry copied to descriptor word three at message start
// - circular mode accesses consecutive words from the current pointer
// - circular mode writes back pointer after last word at message end
// - option suppresses circular update after an invalid receive or broadcast
// - circular buffers aligned on their size and wrap to their start
// - double buffering only for receive and broadcast, selected per subaddress
// - double buffer mode stores data into the active block
// - valid double-buffered message toggles pointer bit 5 and writes it back
// - descriptor words three and four written at message start only
`ifndef RTBM_DEFS_VH
`define RTBM_DEFS_VH
`define RTBM_SP_A        16'h0100
`define RTBM_SP_B        16'h0104
`define RTBM_LUT_A       16'h0140
`define RTBM_LUT_B       16'h01C0
`define RTBM_LUT_TX      16'h0020
`define RTBM_LUT_BC      16'h0040
`define RTBM_LUT_SACW    16'h0060
`define RTBM_MCI_TABLE   16'h0108
`define RTBM_AREA_BIT    13
`define RTBM_DBL_BIT     5
`define RTBM_MAX_BLOCK   32
// subaddress control word field positions (per direction, unshifted for bcst, shift by 5 for rx, 10 for tx; DBL is bit 15 of the whole word, never shifted)
`define RTBM_SACW_SIZE_LO 0
`define RTBM_SACW_CIRC_IRQ 3
`define RTBM_SACW_MSG_IRQ  4
`define RTBM_SACW_DBL     15
`define RTBM_REG_CFG1    4'h0
`define RTBM_REG_STAT    4'h1
`define RTBM_REG_PTR     4'h2
`define RTBM_REG_IRQ     4'h3
`endif

// ---- core/rtbm_ptr_calc.v ----
`timescale 1ns/1ps
module rtbm_ptr_calc (
  input  wire [15:0] ptr,
  input  wire [2:0]  size_code,
  input  wire [5:0]  count,
  output reg  [15:0] next_ptr,
  output reg         wrapped
);
  reg [15:0] mask;
  reg [15:0] low;
  always @* begin
    mask = 16'h0000;
    low = 16'h0000;
    next_ptr = ptr;
    wrapped = 1'b0;
    if (size_code != 3'h0) begin
      mask = (16'h0080 << (size_code - 3'h1)) - 16'h0001;
      low = ((ptr & mask) + {10'h000, count}) & mask;
      next_ptr = (ptr & ~mask) | low;
      wrapped = ((ptr & mask) + {10'h000, count}) > mask;
    end
  end
endmodule

// ---- core/rtbm_regs.v ----
`timescale 1ns/1ps
`include "rtbm_defs.vh"
module rtbm_regs (
  input  wire        mclk,
  input  wire        resetn,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire [15:0] stat_in,
  input  wire [15:0] ptr_in,
  input  wire [15:0] irq_in,
  output reg  [15:0] cfg1
);
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg1 <= 16'h0000;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `RTBM_REG_CFG1)
        cfg1 <= reg_wdata;
      if (reg_rd) begin
        case (reg_addr)
          `RTBM_REG_CFG1: reg_rdata <= cfg1;
          `RTBM_REG_STAT: reg_rdata <= stat_in;
          `RTBM_REG_PTR:  reg_rdata <= ptr_in;
          `RTBM_REG_IRQ:  reg_rdata <= irq_in;
          default:        reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end
endmodule

// ---- verif/rtbm_ram_model.sv ----
`timescale 1ns/1ps
module rtbm_ram_model (
  input  wire        mclk,
  input  wire [15:0] ram_addr,
  input  wire [15:0] ram_wdata,
  input  wire        ram_wr,
  input  wire        ram_rd,
  input  wire [3:0]  lat,
  output logic [15:0] ram_rdata,
  output logic        ram_ack
);
  logic [15:0] mem [0:65535];
  logic [3:0]  cnt;
  initial begin
    ram_ack   = 1'b0;
    ram_rdata = 16'h0000;
    cnt       = 4'h0;
  end
  // one ack per word, after lat waiting cycles; released bus toggles
  always @(posedge mclk) begin
    ram_ack <= 1'b0;
    if ((ram_rd || ram_wr) && !ram_ack) begin
      if (cnt == lat) begin
        ram_ack <= 1'b1;
        cnt     <= 4'h0;
        if (ram_wr)
          mem[ram_addr] <= ram_wdata;
        ram_rdata <= mem[ram_addr];
      end else
        cnt <= cnt + 4'h1;
    end else if (!ram_ack)
      ram_rdata <= ~ram_rdata;
  end
endmodule

// ---- verif/rtbm_manager_monitor.sv ----
`timescale 1ns/1ps
module rtbm_manager_monitor (
  input wire        mclk,
  input wire        resetn,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        msg_start,
  input wire        busy,
  input wire        word_ack,
  input wire        irq_msg,
  input wire        irq_rollover,
  input wire [15:0] ram_addr,
  input wire [15:0] ram_wdata,
  input wire        ram_wr,
  input wire        ram_rd,
  input wire        ram_ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [6:0] nwords;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn)
      nwords <= 7'h00;
    else if (msg_start && !busy)
      nwords <= 7'h00;
    else if (word_ack)
      nwords <= nwords + 7'h01;
  end
  a_block_limit: assert property (nwords <= 7'h20)
    else $error("data block longer than limit");
  a_lut_first: assert property (msg_start && !busy |=> ram_rd)
    else $error("lookup read not issued after start");
  a_busy_start: assert property (msg_start && !busy |=> busy)
    else $error("busy not raised after start");
  a_rd_hold: assert property (ram_rd && !ram_ack |=> ram_rd && $stable(ram_addr))
    else $error("ram read dropped before ack");
  a_wr_hold: assert property (ram_wr && !ram_ack |=> ram_wr && $stable(ram_wdata))
    else $error("ram write dropped before ack");
  a_one_strobe: assert property (!(ram_rd && ram_wr))
    else $error("ram read and write together");
  a_word_after: assert property (word_ack |-> $past(ram_ack))
    else $error("word ack without ram ack");
  a_msg_pulse: assert property (irq_msg |=> !irq_msg)
    else $error("message irq longer than one cycle");
  a_roll_pulse: assert property (irq_rollover |-> ##1 !irq_rollover)
    else $error("rollover irq longer than one cycle");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  c_roll: cover property (irq_rollover);
  c_msg: cover property (irq_msg);
  c_write: cover property (ram_wr && ram_ack);
endmodule
bind rtbm_manager rtbm_manager_monitor i_mon (
  .mclk(mclk), .resetn(resetn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .msg_start(msg_start), .busy(busy), .word_ack(word_ack), .irq_msg(irq_msg),
  .irq_rollover(irq_rollover), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
  .ram_wr(ram_wr), .ram_rd(ram_rd), .ram_ack(ram_ack)
);

// ---- verif/rtbm_manager_bench.sv ----
`timescale 1ns/1ps
`include "rtbm_defs.vh"
module rtbm_manager_bench;
  logic mclk, resetn, reg_wr, reg_rd, msg_start, cmd_bcst, bcst_sep, legacy_compat_mode;
  logic no_upd_invalid, word_req, msg_end, msg_valid, busy, word_ack;
  logic irq_msg, irq_rollover, irq_mode, ram_wr, ram_rd, ram_ack;
  logic [3:0]  reg_addr, lat;
  logic [15:0] reg_wdata, reg_rdata, cmd_word, word_wdata, word_rdata, desc_addr;
  logic [15:0] ram_addr, ram_wdata, ram_rdata, rd;
  int err_total, num_checks, roll_cnt, msgi_cnt;
  rtbm_manager i_dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .msg_start(msg_start), .cmd_word(cmd_word), .cmd_bcst(cmd_bcst), .bcst_sep(bcst_sep),
    .legacy_compat_mode(legacy_compat_mode), .no_upd_invalid(no_upd_invalid),
    .word_req(word_req), .word_wdata(word_wdata), .word_rdata(word_rdata),
    .word_ack(word_ack), .msg_end(msg_end), .msg_valid(msg_valid), .desc_addr(desc_addr),
    .busy(busy), .irq_msg(irq_msg), .irq_rollover(irq_rollover), .irq_mode(irq_mode),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_wr(ram_wr), .ram_rd(ram_rd),
    .ram_rdata(ram_rdata), .ram_ack(ram_ack));
  rtbm_ram_model i_ram (.mclk(mclk), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_wr(ram_wr), .ram_rd(ram_rd), .lat(lat), .ram_rdata(ram_rdata), .ram_ack(ram_ack));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    roll_cnt += (irq_rollover === 1'b1);
    msgi_cnt += (irq_msg === 1'b1);
  end
  task automatic check(input [15:0] seen, input [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic reg_write(input [3:0] a, input [15:0] d);
    @(posedge mclk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk); reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input [3:0] a, output [15:0] d);
    @(posedge mclk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk); reg_rd <= 1'b0;
    @(posedge mclk); d = reg_rdata;
  endtask
  // one message: n data words, tx words compared with ram from txb
  task automatic msg(input [15:0] cmd, input int n, input v, input [15:0] txb);
    int i, w;
    @(posedge mclk); msg_start <= 1'b1; cmd_word <= cmd;
    @(posedge mclk); msg_start <= 1'b0;
    for (i = 0; i < n; i++) begin
      word_req <= 1'b1; word_wdata <= 16'hD000 + 16'(i);
      w = 0;
      do begin @(posedge mclk); w++; end while (word_ack !== 1'b1 && w < 200);
      word_req <= 1'b0;
      if (cmd[10]) check(word_rdata, i_ram.mem[txb + 16'(i)], "tx word");
      @(posedge mclk);
    end
    msg_valid <= v; msg_end <= 1'b1;
    @(posedge mclk); msg_end <= 1'b0;
    w = 0;
    while (busy !== 1'b0 && w < 200) begin @(posedge mclk); w++; end
    check(busy, 1'b0, "idle after message");
  endtask
  initial begin
    #(40 * 20000);
    err_total++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, reg_wr, reg_rd, msg_start, cmd_bcst, bcst_sep, legacy_compat_mode} = 7'h00;
    {no_upd_invalid, word_req, msg_end, msg_valid} = 4'h0;
    {reg_addr, lat, reg_wdata, cmd_word, word_wdata} = 56'h0;
    desc_addr = 16'h0010;
    err_total = 0; num_checks = 0; roll_cnt = 0; msgi_cnt = 0;
    i_ram.mem[16'h0162] = 16'h0500; i_ram.mem[16'h01A2] = 16'h0000;
    i_ram.mem[16'h0500] = 16'hA5A5; i_ram.mem[16'h0501] = 16'h5A5A;
    i_ram.mem[16'h0520] = 16'h1234;
    i_ram.mem[16'h0141] = 16'h047E; i_ram.mem[16'h01A1] = 16'h0320;
    i_ram.mem[16'h0143] = 16'h0600; i_ram.mem[16'h01A3] = 16'h8000;
    i_ram.mem[16'h01E2] = 16'h0700; i_ram.mem[16'h0222] = 16'h0000;
    i_ram.mem[16'h0700] = 16'h0F0F;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    reg_read(`RTBM_REG_CFG1, rd); check(rd, 16'h0000, "cfg1 reset");
    reg_read(4'hF, rd); check(rd, 16'h0000, "unmapped read");
    msg(16'h0C42, 2, 1'b1, 16'h0500);
    check(i_ram.mem[16'h0162], 16'h0500, "single pointer");
    check(i_ram.mem[16'h0012], 16'h0500, "desc pointer");
    check(i_ram.mem[16'h0013], 16'h0C42, "desc command");
    i_ram.mem[16'h0162] = 16'h0520;
    msg(16'h0C41, 1, 1'b1, 16'h0520);
    check(i_ram.mem[16'h0012], 16'h0520, "rewritten pointer");
    $display("single message done");
    msg(16'h0824, 4, 1'b1, 16'h0000);
    check(i_ram.mem[16'h047F], 16'hD001, "circ word 1");
    check(i_ram.mem[16'h0400], 16'hD002, "circ wrap word");
    check(i_ram.mem[16'h0141], 16'h0402, "circ pointer");
    check(16'(roll_cnt), 16'h0001, "rollover irq");
    check(16'(msgi_cnt), 16'h0001, "message irq");
    no_upd_invalid <= 1'b1;
    msg(16'h0822, 2, 1'b0, 16'h0000);
    check(i_ram.mem[16'h0141], 16'h0402, "invalid kept");
    no_upd_invalid <= 1'b0;
    msg(16'h0822, 2, 1'b0, 16'h0000);
    check(i_ram.mem[16'h0141], 16'h0404, "invalid moved");
    $display("circular done");
    lat <= 4'h3;
    msg(16'h0862, 2, 1'b1, 16'h0000);
    check(i_ram.mem[16'h0601], 16'hD001, "double active");
    check(i_ram.mem[16'h0143], 16'h0620, "double swap");
    msg(16'h0861, 1, 1'b0, 16'h0000);
    check(i_ram.mem[16'h0143], 16'h0620, "double invalid");
    check(i_ram.mem[i_ram.mem[16'h0143] ^ 16'h0020], 16'hD000, "inactive block");
    $display("double buffer done");
    lat <= 4'h0; legacy_compat_mode <= 1'b1;
    msg(16'h0822, 2, 1'b1, 16'h0000);
    check(i_ram.mem[16'h0141], 16'h0404, "legacy single");
    legacy_compat_mode <= 1'b0;
    i_ram.mem[16'h015E] = 16'h0780; i_ram.mem[16'h01BE] = 16'h0000;
    msg(16'h03C1, 1, 1'b1, 16'h0000);
    check(i_ram.mem[16'h0780], 16'hD000, "wraparound data");
    check(i_ram.mem[16'h015E], 16'h0780, "wraparound pointer");
    reg_write(`RTBM_REG_CFG1, 16'h2000);
    reg_read(`RTBM_REG_CFG1, rd); check(rd, 16'h2000, "cfg1 area");
    msg(16'h0C41, 1, 1'b1, 16'h0700);
    check(i_ram.mem[16'h0012], 16'h0700, "area b pointer");
    $display("legacy and area done");
    report_and_stop;
  end
endmodule
